//--- scds_cfg.svh
`ifndef SCDS_CFG_SVH
`define SCDS_CFG_SVH
// ----------------------------------------
// Register map and field positions
// ----------------------------------------
`define SCDS_ADDR_CLK_SYNC 9'h100
`define SCDS_BIT_SYNC_EN 1
`define SCDS_BIT_SYNC_ONCE 2
`define SCDS_RST_CLK_SYNC 8'h00
// ----------------------------------------
// Timing figures
// ----------------------------------------
`define SCDS_CLK_PERIOD_PS 5000
`define SCDS_RELOCK_MIN_PS 1500000
`define SCDS_DCS_MIN_MHZ 20
`define SCDS_DIV_MAX 8
`define SCDS_STANDBY_WAKE_CYC 16
`endif

//--- scds_pkg.sv
package scds_pkg;
    typedef enum logic [1:0] {
        SCDS_PWR_ACTIVE = 2'b00,
        SCDS_PWR_STANDBY = 2'b01,
        SCDS_PWR_DOWN = 2'b10,
        SCDS_PWR_WAKE = 2'b11
    } scds_pwr_type;
endpackage : scds_pkg

//--- scds_top.sv
// Function
// RULE_01 - Divide input clock by one to eight
// RULE_02 - Host enables stabiliser for odd ratios
// RULE_03 - Clock_sync_control picks every or first strobe
// RULE_04 - Accepted strobe resets divider counter
// RULE_05 - Strobe synchronised before reaching divider
// RULE_06 - Host drives strobe synchronous to clock
// RULE_07 - Stabiliser gives fifty percent high time; sample_clk is high for (ratio+1)/2 of ratio cycles, above half for odd ratios
// RULE_08 - Stabiliser inactive below twenty megahertz
// RULE_09 - Relock wait after clock rate change
// RULE_10 - Power-down by pin or serial command
// RULE_11 - Outputs released while powered down
// RULE_12 - Pin low returns to normal operation
// RULE_13 - Power-down stops reference, bias, clock
// RULE_14 - Standby keeps reference powered, faster wake
// RULE_15 - Sense at supply selects external reference
// RULE_16 - Pin mode: stabiliser on unless grounded
// RULE_17 - One sampling edge per ratio cycles
// RULE_18 - Single-shot ignores strobes after first
`include "scds_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module scds_top
    import scds_pkg::*;
#(
    parameter int CLK_MHZ = 200,
    parameter int WAKE_MAX_CYC = 8192
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reg_wr_en,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    input wire logic [2:0] div_ratio_m1,
    input wire logic serial_mode,
    input wire logic serial_dcs_en,
    input wire logic serial_power_down,
    input wire logic serial_standby,
    input wire logic clk_rate_change,
    input wire logic sync_pin,
    input wire logic power_off_pin,
    input wire logic sense_pin,
    input wire logic serial_io_stabilizer_select_pin,
    output logic sample_clk,
    output logic sample_strobe,
    output logic dcs_active,
    output logic dcs_locked,
    output logic data_oe,
    output logic ref_int_en,
    output logic ref_buf_en,
    output logic bias_en,
    output logic conv_ready,
    output logic [1:0] pwr_state
);
    localparam int RELOCK_CYC = (`SCDS_RELOCK_MIN_PS + `SCDS_CLK_PERIOD_PS - 1) / `SCDS_CLK_PERIOD_PS;
    // Refuse parameter values that the counters cannot hold
    if (WAKE_MAX_CYC < 2 || WAKE_MAX_CYC > 65535) begin : g_bad_wake
        $error("WAKE_MAX_CYC out of range");
    end
    if (CLK_MHZ < 1) begin : g_bad_clk
        $error("CLK_MHZ out of range");
    end
    if (RELOCK_CYC > 1023) begin : g_bad_relock
        $error("relock count too wide");
    end

    // ----------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------
    logic rst_s1_r, rst_s2_r;
    logic [3:0] pin_s1_r, pin_s2_r;
    logic sync_d_r;
    // Reset held asynchronously, released through two flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    wire rstn = rst_s2_r;
    // Two-flop synchronisers for every pin
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            sync_d_r <= 1'b0;
        end else begin
            pin_s1_r <= {serial_io_stabilizer_select_pin, sense_pin, power_off_pin, sync_pin}; // see RULE_05
            pin_s2_r <= pin_s1_r;
            sync_d_r <= pin_s2_r[0];
        end
    end
    wire sync_rise = pin_s2_r[0] & ~sync_d_r;
    wire power_off_pin_pin = pin_s2_r[1];
    wire sense_at_supply = pin_s2_r[2];
    wire dcs_sel_pin = pin_s2_r[3];

    // ----------------------------------------
    // Synchronisation control register
    // ----------------------------------------
    logic [7:0] sync_ctl_r;
    logic armed_r;
    wire ctl_wr = reg_wr_en && reg_addr == `SCDS_ADDR_CLK_SYNC;
    wire sync_en = sync_ctl_r[`SCDS_BIT_SYNC_EN];
    wire sync_once = sync_ctl_r[`SCDS_BIT_SYNC_ONCE];
    wire sync_accept = sync_rise && sync_en && (!sync_once || armed_r); // see RULE_03 see RULE_18
    // Register store, single-shot arming; a write beats a coincident strobe
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sync_ctl_r <= `SCDS_RST_CLK_SYNC;
            armed_r <= 1'b0;
            reg_rd_data <= 8'h00;
        end else begin
            if (ctl_wr) sync_ctl_r <= reg_wr_data;
            if (ctl_wr) armed_r <= 1'b1; // see RULE_03
            else if (sync_accept) armed_r <= 1'b0; // see RULE_18
            reg_rd_data <= (reg_addr == `SCDS_ADDR_CLK_SYNC) ? {sync_ctl_r[7:3], armed_r & sync_once, sync_ctl_r[1:0]} : 8'h00;
        end
    end

    // ----------------------------------------
    // Power state machine
    // ----------------------------------------
    scds_pwr_type pwr_r, pwr_nxt;
    logic [15:0] down_cnt_r, wake_cnt_r;
    wire pd_req = power_off_pin_pin || (serial_mode && serial_power_down); // see RULE_10
    wire sb_req = serial_mode && serial_standby; // see RULE_14
    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            SCDS_PWR_ACTIVE: begin
                if (pd_req) pwr_nxt = SCDS_PWR_DOWN;
                else if (sb_req) pwr_nxt = SCDS_PWR_STANDBY;
            end
            SCDS_PWR_STANDBY: begin
                if (pd_req) pwr_nxt = SCDS_PWR_DOWN;
                else if (!sb_req) pwr_nxt = SCDS_PWR_WAKE;
            end
            SCDS_PWR_DOWN: begin
                if (!pd_req) pwr_nxt = sb_req ? SCDS_PWR_STANDBY : SCDS_PWR_WAKE; // see RULE_12
            end
            SCDS_PWR_WAKE: begin
                if (pd_req) pwr_nxt = SCDS_PWR_DOWN;
                else if (wake_cnt_r == 16'h0000) pwr_nxt = SCDS_PWR_ACTIVE;
            end
            default: pwr_nxt = SCDS_PWR_DOWN;
        endcase
    end
    // Time spent down sets the wake delay; standby wakes in a short fixed time
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pwr_r <= SCDS_PWR_ACTIVE;
            down_cnt_r <= 16'h0000;
            wake_cnt_r <= 16'h0000;
        end else begin
            pwr_r <= pwr_nxt;
            if (pwr_r == SCDS_PWR_DOWN) begin
                if (down_cnt_r < 16'(WAKE_MAX_CYC)) down_cnt_r <= down_cnt_r + 16'h0001; // see RULE_13
            end else if (pwr_r == SCDS_PWR_ACTIVE) begin
                down_cnt_r <= 16'h0000;
            end
            if (pwr_nxt == SCDS_PWR_WAKE && pwr_r != SCDS_PWR_WAKE)
                wake_cnt_r <= (pwr_r == SCDS_PWR_DOWN) ? down_cnt_r : 16'(`SCDS_STANDBY_WAKE_CYC); // see RULE_14
            else if (wake_cnt_r != 16'h0000)
                wake_cnt_r <= wake_cnt_r - 16'h0001;
        end
    end
    // States in which the internal clock and bias run
    function automatic logic run_state(input scds_pwr_type s);
        run_state = s == SCDS_PWR_ACTIVE || s == SCDS_PWR_WAKE;
    endfunction : run_state
    wire clk_run = run_state(pwr_r);

    // ----------------------------------------
    // Clock divider and duty-cycle stabiliser
    // ----------------------------------------
    logic [2:0] div_cnt_r;
    logic [9:0] relock_cnt_r;
    wire dcs_en_sel = serial_mode ? serial_dcs_en : dcs_sel_pin; // see RULE_16
    wire dcs_on = dcs_en_sel && CLK_MHZ >= `SCDS_DCS_MIN_MHZ; // see RULE_08
    wire [2:0] cnt_nxt = (sync_accept || !clk_run || div_cnt_r >= div_ratio_m1) ? 3'h0 : div_cnt_r + 3'h1; // see RULE_01 see RULE_04
    wire [3:0] ratio = {1'b0, div_ratio_m1} + 4'h1;
    wire [3:0] high_len = dcs_on ? ((ratio + 4'h1) >> 1) : 4'h1; // see RULE_07
    // Divider counter; edge on count zero, pulse length from stabiliser
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt_r <= 3'h0;
            sample_clk <= 1'b0;
            sample_strobe <= 1'b0;
            relock_cnt_r <= 10'h000;
            dcs_active <= 1'b0;
            dcs_locked <= 1'b0;
        end else begin
            div_cnt_r <= cnt_nxt;
            sample_strobe <= clk_run && cnt_nxt == 3'h0; // see RULE_17
            sample_clk <= clk_run && {1'b0, cnt_nxt} < high_len; // see RULE_07
            dcs_active <= dcs_on;
            if (clk_rate_change || !dcs_on) relock_cnt_r <= 10'(RELOCK_CYC); // see RULE_09
            else if (relock_cnt_r != 10'h000) relock_cnt_r <= relock_cnt_r - 10'h001;
            dcs_locked <= dcs_on && relock_cnt_r == 10'h000 && !clk_rate_change;
        end
    end

    // ----------------------------------------
    // Power and reference outputs
    // ----------------------------------------
    // Analog enables follow the next state
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            data_oe <= 1'b0;
            ref_int_en <= 1'b0;
            ref_buf_en <= 1'b0;
            bias_en <= 1'b0;
            conv_ready <= 1'b0;
            pwr_state <= 2'b00;
        end else begin
            data_oe <= pwr_nxt != SCDS_PWR_DOWN; // see RULE_11
            ref_int_en <= pwr_nxt != SCDS_PWR_DOWN && !sense_at_supply; // see RULE_13 see RULE_15
            ref_buf_en <= run_state(pwr_nxt); // see RULE_13
            bias_en <= run_state(pwr_nxt); // see RULE_13
            conv_ready <= pwr_nxt == SCDS_PWR_ACTIVE; // see RULE_12
            pwr_state <= pwr_nxt;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_div_period: assert property (@(posedge sys_clk) disable iff (!rstn) // see RULE_17
        sample_strobe && clk_run && $stable(div_ratio_m1) && !sync_accept && div_ratio_m1 == 3'h3
        |=> !sample_strobe [*3] ##1 (sample_strobe || sync_accept || !clk_run || !$stable(div_ratio_m1)))
        else $error("divider period wrong");
    a_sync_reset: assert property (@(posedge sys_clk) disable iff (!rstn) // see RULE_04
        sync_accept && clk_run |=> div_cnt_r == 3'h0 && sample_strobe)
        else $error("strobe did not reset divider");
    a_once_ignore: assert property (@(posedge sys_clk) disable iff (!rstn) // see RULE_18
        sync_accept && sync_once && !ctl_wr |=> !armed_r)
        else $error("single shot not disarmed");
    a_sync_path: assert property (@(posedge sys_clk) disable iff (!rstn) // see RULE_05
        sync_accept |-> !$past(pin_s2_r[0]) && $past(sync_pin, 2))
        else $error("strobe bypassed synchroniser");
    a_power_off_pin_enter: assert property (@(posedge sys_clk) disable iff (!rstn) // see RULE_10
        pd_req |=> pwr_r == SCDS_PWR_DOWN)
        else $error("power-down not entered");
    a_power_off_pin_hiz: assert property (@(posedge sys_clk) disable iff (!rstn) // see RULE_11
        pwr_r == SCDS_PWR_DOWN |-> !data_oe && !bias_en && !ref_buf_en)
        else $error("outputs driven in power-down");
    a_ext_ref: assert property (@(posedge sys_clk) disable iff (!rstn) // see RULE_15
        sense_at_supply |=> !ref_int_en)
        else $error("internal reference left on");
    a_standby_ref: assert property (@(posedge sys_clk) disable iff (!rstn) // see RULE_14
        pwr_r == SCDS_PWR_STANDBY && !sense_at_supply |-> ref_int_en && !bias_en)
        else $error("standby reference wrong");
    a_relock_wait: assert property (@(posedge sys_clk) disable iff (!rstn) // see RULE_09
        clk_rate_change |=> !dcs_locked [*8])
        else $error("relock too early");
    a_duty_half: assert property (@(posedge sys_clk) disable iff (!rstn) // see RULE_07
        sample_strobe && dcs_on && div_ratio_m1 == 3'h3 && $stable(div_ratio_m1) |-> sample_clk ##1 sample_clk)
        else $error("stabiliser high time wrong");
endmodule : scds_top
`default_nettype wire

//--- scds_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module scds_host_model (
    input wire logic sys_clk,
    output logic sync_pin,
    output logic power_off_pin
);
    // Host pins idle low and change only after the falling edge
    initial begin
        sync_pin = 1'b0;
        power_off_pin = 1'b0;
    end
    // One-cycle alignment strobe launched on the clock's falling edge
    task automatic strobe();
        @(negedge sys_clk);
        sync_pin = 1'b1;
        @(negedge sys_clk);
        sync_pin = 1'b0;
    endtask : strobe
    // Power-down pin level
    task automatic set_power(input logic v);
        @(negedge sys_clk);
        power_off_pin = v;
    endtask : set_power
endmodule : scds_host_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import scds_pkg::*;
;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr_en = 1'b0, serial_mode = 1'b0, serial_dcs_en = 1'b0;
    logic serial_power_down = 1'b0, serial_standby = 1'b0, clk_rate_change = 1'b0, sense_pin = 1'b0;
    logic serial_io_stabilizer_select_pin = 1'b1;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wr_data = 8'h00;
    logic [2:0] div_ratio_m1 = 3'h0;
    logic [7:0] reg_rd_data;
    logic [1:0] pwr_state;
    logic sample_clk, sample_strobe, dcs_active, dcs_locked, data_oe, ref_int_en, ref_buf_en, bias_en, conv_ready;
    wire sync_pin, power_off_pin;
    int err_count = 0, checks = 0, p, h, d, w1, w2;
    // 200 MHz system clock
    always #2.5 sys_clk = ~sys_clk;
    scds_top i_scds_top (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .div_ratio_m1(div_ratio_m1),
        .serial_mode(serial_mode), .serial_dcs_en(serial_dcs_en), .serial_power_down(serial_power_down),
        .serial_standby(serial_standby), .clk_rate_change(clk_rate_change), .sync_pin(sync_pin),
        .power_off_pin(power_off_pin), .sense_pin(sense_pin),
        .serial_io_stabilizer_select_pin(serial_io_stabilizer_select_pin), .sample_clk(sample_clk),
        .sample_strobe(sample_strobe), .dcs_active(dcs_active), .dcs_locked(dcs_locked), .data_oe(data_oe),
        .ref_int_en(ref_int_en), .ref_buf_en(ref_buf_en), .bias_en(bias_en), .conv_ready(conv_ready),
        .pwr_state(pwr_state));
    scds_host_model i_scds_host_model (.sys_clk(sys_clk), .sync_pin(sync_pin), .power_off_pin(power_off_pin));
    // ----------------------------------------
    // Access and measurement tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            err_count++;
        end
    endtask : check
    task automatic end_of_test();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [8:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = v;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        reg_addr = a;
        @(negedge sys_clk);
        check(reg_rd_data, e);
    endtask : rd
    task automatic wait_strobe();
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (sample_strobe !== 1'b1 && n < 40);
    endtask : wait_strobe
    // Period and high time of one divided cycle, after a settling wrap
    task automatic measure();
        wait_strobe();
        wait_strobe();
        p = 0;
        h = 0;
        do begin
            if (sample_clk === 1'b1) h++;
            @(negedge sys_clk);
            p++;
        end while (sample_strobe !== 1'b1 && p < 20);
    endtask : measure
    // Strobe two cycles after a sampling edge; d counts edges to the next one
    task automatic sync_try();
        wait_strobe();
        @(negedge sys_clk);
        i_scds_host_model.strobe();
        d = 1;
        while (sample_strobe !== 1'b1 && d < 12) begin
            @(negedge sys_clk);
            d++;
        end
    endtask : sync_try
    task automatic await_ready(output int w);
        w = 0;
        while (conv_ready !== 1'b1 && w < 9000) begin
            @(negedge sys_clk);
            w++;
        end
    endtask : await_ready
    task automatic pcycle(input int cyc, output int w);
        i_scds_host_model.set_power(1'b1);
        repeat (cyc) @(negedge sys_clk);
        check(data_oe, 1'b0);
        check({ref_int_en, ref_buf_en, bias_en, conv_ready}, 4'h0);
        check(pwr_state, SCDS_PWR_DOWN);
        i_scds_host_model.set_power(1'b0);
        await_ready(w);
        check(data_oe, 1'b1);
        check({ref_buf_en, bias_en}, 2'h3);
    endtask : pcycle
    // ----------------------------------------
    // Test sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        rd(9'h100, 8'h00);
        rd(9'h0ff, 8'h00);
        for (int i = 0; i < 8; i++) begin
            div_ratio_m1 = 3'(i);
            measure();
            check(16'(p), 16'(i + 1));
        end
        div_ratio_m1 = 3'h4;
        measure();
        check(16'(h), 16'h3);
        check(dcs_active, 1'b1);
        serial_io_stabilizer_select_pin = 1'b0;
        measure();
        check(dcs_active, 1'b0);
        check(16'(h), 16'h1);
        serial_io_stabilizer_select_pin = 1'b1;
        div_ratio_m1 = 3'h7;
        measure();
        check(16'(p), 16'h8);
        wr(9'h100, 8'h02);
        sync_try();
        check(d <= 4, 1'b1);
        sync_try();
        check(d <= 4, 1'b1);
        wr(9'h100, 8'h00);
        sync_try();
        check(16'(d), 16'h6);
        wr(9'h100, 8'h06);
        rd(9'h100, 8'h06);
        sync_try();
        check(d <= 4, 1'b1);
        rd(9'h100, 8'h02);
        sync_try();
        check(16'(d), 16'h6);
        wr(9'h100, 8'h06);
        sync_try();
        check(d <= 4, 1'b1);
        pcycle(20, w1);
        pcycle(80, w2);
        check(w2 > w1, 1'b1);
        serial_mode = 1'b1;
        serial_dcs_en = 1'b1;
        serial_standby = 1'b1;
        repeat (5) @(negedge sys_clk);
        check({pwr_state, ref_int_en}, {SCDS_PWR_STANDBY, 1'b1});
        serial_standby = 1'b0;
        await_ready(w1);
        check(w1 <= 20, 1'b1);
        serial_power_down = 1'b1;
        repeat (5) @(negedge sys_clk);
        check({pwr_state, data_oe}, {SCDS_PWR_DOWN, 1'b0});
        serial_power_down = 1'b0;
        await_ready(w1);
        check(conv_ready, 1'b1);
        clk_rate_change = 1'b1;
        @(negedge sys_clk);
        clk_rate_change = 1'b0;
        repeat (5) @(negedge sys_clk);
        check(dcs_locked, 1'b0);
        repeat (300) @(negedge sys_clk);
        check(dcs_locked, 1'b1);
        sense_pin = 1'b1;
        repeat (5) @(negedge sys_clk);
        check(ref_int_en, 1'b0);
        end_of_test();
    end
    initial begin
        #100us;
        err_count++;
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
